// ### hdl/svmon_pkg.sv
// package: register map, fields and reset values of the supply monitor
package svmon_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFF    = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_OFF    = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0c;
  // configuration field positions
  localparam int CFG_PWRD_BIT  = 0;
  localparam int CFG_RSTD_BIT  = 1;
  localparam int CFG_STOP_BIT  = 2;
  localparam int CFG_TRIP_BIT  = 3;
  localparam int CFG_W         = 4;
  // status and interrupt field positions
  localparam int STAT_LOW_BIT  = 0;
  localparam int STAT_RST_BIT  = 1;
  localparam int STAT_GATE_BIT = 2;
  localparam int IRQ_LOW_BIT   = 0;
  localparam int IRQ_RST_BIT   = 1;
  localparam int IRQ_W         = 2;
  // reset values: monitor powered, resets on, 3 V thresholds
  localparam logic [CFG_W-1:0] CFG_RST  = 4'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;
  // synchroniser depth
  localparam int SYNC_STAGES = 2;
  // trip level encoding
  typedef enum logic {trip_3v_type_e = 1'b0, trip_5v_type_e = 1'b1}
    svmon_trip_type;
endpackage : svmon_pkg

// ### hdl/svmon_sync.sv
// module: level synchroniser for the asynchronous comparator output
`timescale 1ns/1ns
module svmon_sync #(
  parameter int  STAGES = 2,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic hclk,     // bus clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic d,        // asynchronous level
  output logic      q         // synchronised level
);
  logic [STAGES-1:0] stage_r;
  logic [STAGES-1:0] stage_nxt;

  // shift chain; only the last stage is read outside
  always_comb begin
    stage_nxt = {stage_r[STAGES-2:0], d};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_r <= {STAGES{RST_VAL}};
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign q = stage_r[STAGES-1];
endmodule : svmon_sync

// ### hdl/svmon_top.sv
// module: supply monitor control logic with ahb-lite registers
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
// Behaviour
// - out of reset the monitor is powered and armed before any write
// - power-disable zero keeps comparator powered; one switches monitor off
// - reset-disable zero and powered: low comparator output asserts reset
// - stop-enable one keeps monitoring alive during stop mode
// - trip select one picks 5 V thresholds, zero picks 3 V
// - trip select defaults to 3 V after power-on reset
// - selecting 5 V while below its falling level enters reset at once
// - reset held until comparator reports supply above rising level
// - read-only status flag mirrors comparator, even with resets off
// - rising release level sits a hysteresis margin above falling level
module svmon_top (
  input  wire logic        hclk,           // bus clock, 125 MHz
  input  wire logic        hresetn,        // async reset, active low
  input  wire logic        hsel,           // slave select
  input  wire logic [7:0]  haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write strobe
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready in
  output logic [31:0]      hrdata,         // read data
  output logic             hreadyout,      // slave ready
  output logic             hresp,          // always okay
  input  wire logic        cmp_low,        // comparator: supply below level
  input  wire logic        stop_mode,      // processor in stop mode
  output logic             monitor_power,  // powers reference and comparator
  output logic             trip_level_select, // 1 = 5 V thresholds
  output logic             lv_reset_req,   // to reset sequencer, active high
  output logic             irq             // level interrupt
);
  // configuration
  logic [svmon_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  // status, interrupt and mask
  logic                        low_flag_r, low_flag_nxt;
  logic                        rst_hold_r, rst_hold_nxt;
  logic [svmon_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [svmon_pkg::IRQ_W-1:0] mask_r, mask_nxt;
  // bus data phase capture
  logic                        wr_pend_r, wr_pend_nxt;
  logic [7:0]                  wr_addr_r, wr_addr_nxt;
  logic [31:0]                 hrdata_nxt;
  // outputs
  logic                        pwr_r, pwr_nxt;
  logic                        trip_r, trip_nxt;
  logic                        irq_r, irq_nxt;
  logic                        cmp_sync;
  logic                        active;
  logic                        addr_ph;
  logic [svmon_pkg::IRQ_W-1:0] irq_evt, irq_clr;

  // comparator output synchronised before any use
  svmon_sync #(
    .STAGES  (svmon_pkg::SYNC_STAGES),
    .RST_VAL (1'b0)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (cmp_low),
    .q       (cmp_sync)
  );

  // monitor runs when powered and not gated by stop mode
  always_comb begin
    active = !cfg_r[svmon_pkg::CFG_PWRD_BIT] &&
             (!stop_mode || cfg_r[svmon_pkg::CFG_STOP_BIT]);
  end

  // low flag and reset hold; the analog comparator supplies the falling
  // and rising thresholds, so its output already carries the hysteresis
  always_comb begin
    low_flag_nxt = low_flag_r;
    rst_hold_nxt = rst_hold_r;
    if (active) begin
      low_flag_nxt = cmp_sync;
      // held while comparator still low, released once it reports high
      if (!cfg_r[svmon_pkg::CFG_RSTD_BIT] && cmp_sync) begin
        rst_hold_nxt = 1'b1;
      end else if (!cmp_sync) begin
        rst_hold_nxt = 1'b0;
      end
    end else if (cfg_r[svmon_pkg::CFG_PWRD_BIT]) begin
      // powered off: nothing to report, drop any hold
      low_flag_nxt = 1'b0;
      rst_hold_nxt = 1'b0;
    end
    // gated by stop mode: both stay frozen
  end

  // ahb-lite address phase qualifier
  always_comb begin
    addr_ph = hsel && hready && htrans[1];
  end

  // write capture and config update
  always_comb begin
    wr_pend_nxt = addr_ph && hwrite;
    wr_addr_nxt = addr_ph ? haddr : wr_addr_r;
    cfg_nxt     = cfg_r;
    mask_nxt    = mask_r;
    irq_clr     = '0;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        svmon_pkg::CFG_OFF:  cfg_nxt  = hwdata[svmon_pkg::CFG_W-1:0];
        svmon_pkg::MASK_OFF: mask_nxt = hwdata[svmon_pkg::IRQ_W-1:0];
        svmon_pkg::IRQ_OFF:  irq_clr  = hwdata[svmon_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events: new low detect, new reset assertion; set beats clear
  always_comb begin
    irq_evt = '0;
    irq_evt[svmon_pkg::IRQ_LOW_BIT] = low_flag_nxt && !low_flag_r;
    irq_evt[svmon_pkg::IRQ_RST_BIT] = rst_hold_nxt && !rst_hold_r;
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;
    irq_nxt      = |(irq_stat_nxt & mask_nxt);
  end

  // read data for the data phase, registered; unmapped reads return zero
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (addr_ph && !hwrite) begin
      unique case (haddr)
        svmon_pkg::CFG_OFF:
          hrdata_nxt[svmon_pkg::CFG_W-1:0] = cfg_r;
        svmon_pkg::STATUS_OFF: begin
          hrdata_nxt[svmon_pkg::STAT_LOW_BIT]  = low_flag_r;
          hrdata_nxt[svmon_pkg::STAT_RST_BIT]  = rst_hold_r;
          hrdata_nxt[svmon_pkg::STAT_GATE_BIT] = !active;
        end
        svmon_pkg::IRQ_OFF:
          hrdata_nxt[svmon_pkg::IRQ_W-1:0] = irq_stat_r;
        svmon_pkg::MASK_OFF:
          hrdata_nxt[svmon_pkg::IRQ_W-1:0] = mask_r;
        default: ;
      endcase
    end
  end

  // outputs from flops
  always_comb begin
    pwr_nxt  = !cfg_nxt[svmon_pkg::CFG_PWRD_BIT];
    trip_nxt = cfg_nxt[svmon_pkg::CFG_TRIP_BIT];
  end

  // single register stage for all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r      <= svmon_pkg::CFG_RST;
      mask_r     <= svmon_pkg::MASK_RST;
      irq_stat_r <= '0;
      low_flag_r <= 1'b0;
      rst_hold_r <= 1'b0;
      wr_pend_r  <= 1'b0;
      wr_addr_r  <= 8'h00;
      hrdata     <= 32'h0000_0000;
      pwr_r      <= 1'b1;
      trip_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      cfg_r      <= cfg_nxt;
      mask_r     <= mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      low_flag_r <= low_flag_nxt;
      rst_hold_r <= rst_hold_nxt;
      wr_pend_r  <= wr_pend_nxt;
      wr_addr_r  <= wr_addr_nxt;
      hrdata     <= hrdata_nxt;
      pwr_r      <= pwr_nxt;
      trip_r     <= trip_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // zero wait states, okay only: keeps the bus simple
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign monitor_power     = pwr_r;
  assign trip_level_select = trip_r;
  assign lv_reset_req      = rst_hold_r;
  assign irq               = irq_r;
endmodule : svmon_top

// ### sim/svmon_cmp_model.sv
// model: comparator with selectable trip set and hysteresis
`timescale 1ns/1ns
module svmon_cmp_model #(
  parameter logic [15:0] FALL_3V = 16'h09f6, // 3 V falling trip, mV
  parameter logic [15:0] RISE_3V = 16'h0a5a, // 3 V rising release, mV
  parameter logic [15:0] FALL_5V = 16'h1068, // 5 V falling trip, mV
  parameter logic [15:0] RISE_5V = 16'h10cc  // 5 V rising release, mV
) (
  input  wire logic        hclk,            // sampling clock
  input  wire logic [15:0] supply_mv,       // supply, mV
  input  wire logic        powered,         // reference powered
  input  wire logic        sel_5v,          // 5 V set
  output logic             cmp_low = 1'b0   // supply below level
);
  // unpowered output toggles so a stale level never looks valid
  always_ff @(posedge hclk) begin
    if (!powered)
      cmp_low <= !cmp_low;
    else if (supply_mv < (sel_5v ? FALL_5V : FALL_3V))
      cmp_low <= 1'b1;
    else if (supply_mv > (sel_5v ? RISE_5V : RISE_3V))
      cmp_low <= 1'b0;
  end
endmodule : svmon_cmp_model

// ### sim/svmon_sva.sv
// checker: supply monitor port assertions
`timescale 1ns/1ns
module svmon_sva (
  input wire logic        hclk,              // clock
  input wire logic        hresetn,           // reset
  input wire logic        hsel,              // select
  input wire logic [7:0]  haddr,             // address
  input wire logic [1:0]  htrans,            // transfer
  input wire logic        hwrite,            // write
  input wire logic [31:0] hwdata,            // wdata
  input wire logic        hready,            // ready in
  input wire logic        hreadyout,         // ready out
  input wire logic        hresp,             // response
  input wire logic        cmp_low,           // comparator
  input wire logic        monitor_power,     // power
  input wire logic        trip_level_select, // trip set
  input wire logic        lv_reset_req       // reset request
);
  // config write address phase
  wire wr_cfg = hsel && hready && htrans[1] && hwrite && haddr == 8'h00;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cfg_wr;
    wr_cfg ##1 1'b1;
  endsequence
  sequence s_low3;
    cmp_low[*3];
  endsequence
  AST_RESET_STATE: assert property ($rose(hresetn) |-> monitor_power &&
    !trip_level_select && !lv_reset_req) else $error("bad state after reset");
  AST_CFG_WRITE: assert property (s_cfg_wr |=>
    trip_level_select == $past(hwdata[3]) && monitor_power == !$past(hwdata[0]))
    else $error("config write not applied");
  AST_TRIP_ONLY_ON_WRITE: assert property ($changed(trip_level_select) |->
    $past(wr_cfg, 2)) else $error("trip select changed without a write");
  AST_RISE_CAUSE: assert property ($rose(lv_reset_req) |->
    $past(cmp_low, 3) && monitor_power) else $error("reset rose without cause");
  AST_FALL_CAUSE: assert property ($fell(lv_reset_req) |->
    !monitor_power || !$past(cmp_low, 3)) else $error("reset fell early");
  AST_HOLD_LOW: assert property (s_low3 ##0 (lv_reset_req && monitor_power)
    |=> lv_reset_req || !monitor_power) else $error("reset not held");
  AST_OFF_NO_RESET: assert property (!monitor_power && !$past(monitor_power)
    |-> !lv_reset_req) else $error("reset while monitor off");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
endmodule : svmon_sva
bind svmon_top svmon_sva svmon_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .cmp_low, .monitor_power,
  .trip_level_select, .lv_reset_req);

// ### sim/tb.sv
// testbench: supply monitor scenarios over the register bus
`timescale 1ns/1ns
module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        stop_mode = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [15:0] supply_mv = 16'h0ce4;
  logic        hreadyout, hresp, cmp_low, monitor_power, trip_level_select;
  logic        lv_reset_req, irq;
  int          num_errors = 0, checked = 0;
  always #4 hclk = ~hclk;
  svmon_top svmon_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cmp_low, .stop_mode, .monitor_power, .trip_level_select,
    .lv_reset_req, .irq);
  svmon_cmp_model svmon_cmp_model_i (.hclk, .supply_mv,
    .powered(monitor_power), .sel_5v(trip_level_select), .cmp_low);
  task automatic cmp(input string nm, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask : cmp
  // one single transfer; read data taken in the data phase
  task automatic xfer(input logic [7:0] a, input logic w, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // data phase ends at the edge that sees ready; read data taken there
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, logic [31:0] ex, string nm);
    xfer(a, 1'b0, 32'h0);
    cmp(nm, ex, rd);
  endtask : rdc
  // bounded wait: latency is a few cycles, limit is generous
  task automatic wait_for(input string nm, ref logic s, input logic v);
    for (int n = 0; n < 12 && s !== v; n++) @(negedge hclk);
    cmp(nm, {31'h0, v}, {31'h0, s});
  endtask : wait_for
  task automatic supply(input logic [15:0] mv);
    @(posedge hclk);
    supply_mv <= mv;
    repeat (8) @(negedge hclk);
  endtask : supply
  task automatic t_reset;
    cmp("power", 32'h1, {31'h0, monitor_power});
    rdc(8'h00, 32'h0, "config");
    rdc(8'h0c, 32'h0, "mask");
    rdc(8'h10, 32'h0, "unmapped");
    xfer(8'h00, 1'b1, 32'h1);
    wait_for("power", monitor_power, 1'b0);
    xfer(8'h00, 1'b1, 32'h0);
    // stale synchroniser levels after re-power may set sticky bits
    supply(16'h0ce4);
    xfer(8'h08, 1'b1, 32'h3);
    rdc(8'h08, 32'h0, "irq status");
  endtask : t_reset
  task automatic t_forced;
    xfer(8'h0c, 1'b1, 32'h2);
    supply(16'h07d0);
    wait_for("reset", lv_reset_req, 1'b1);
    rdc(8'h04, 32'h3, "status");
    wait_for("irq", irq, 1'b1);
    supply(16'h0a28);
    cmp("reset", 32'h1, {31'h0, lv_reset_req});
    supply(16'h0ce4);
    wait_for("reset", lv_reset_req, 1'b0);
    xfer(8'h08, 1'b1, 32'h3);
    wait_for("irq", irq, 1'b0);
  endtask : t_forced
  task automatic t_polled;
    xfer(8'h00, 1'b1, 32'h2);
    supply(16'h07d0);
    cmp("reset", 32'h0, {31'h0, lv_reset_req});
    rdc(8'h04, 32'h1, "status");
    supply(16'h0ce4);
    xfer(8'h00, 1'b1, 32'h8);
    wait_for("reset", lv_reset_req, 1'b1);
    supply(16'h1388);
    wait_for("reset", lv_reset_req, 1'b0);
  endtask : t_polled
  task automatic t_stop;
    xfer(8'h00, 1'b1, 32'h0);
    stop_mode <= 1'b1;
    supply(16'h07d0);
    cmp("reset", 32'h0, {31'h0, lv_reset_req});
    xfer(8'h00, 1'b1, 32'h4);
    wait_for("reset", lv_reset_req, 1'b1);
  endtask : t_stop
  task automatic stop_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_forced();
    t_polled();
    t_stop();
    stop_test();
  end
  // watchdog: the run needs well under 1000 cycles
  initial begin
    #40000;
    num_errors++;
    stop_test();
  end
endmodule : tb
